//--- core/ics_input_clock_selector.sv
// input clock selector with its axi4-lite register file
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
module ics_input_clock_selector
	import ics_pkg::*;
(
	input  wire logic             ref_clk_i,       // 100 MHz device clock
	input  wire logic             reset_i,         // async, active high
	input  wire logic [AW-1:0]    s_axi_awaddr_i,  // write address
	input  wire logic             s_axi_awvalid_i, // write address valid
	output logic                  s_axi_awready_o, // write address ready
	input  wire logic [DW-1:0]    s_axi_wdata_i,   // write data
	input  wire logic [DW/8-1:0]  s_axi_wstrb_i,   // write byte lanes
	input  wire logic             s_axi_wvalid_i,  // write data valid
	output logic                  s_axi_wready_o,  // write data ready
	output logic [1:0]            s_axi_bresp_o,   // write response
	output logic                  s_axi_bvalid_o,  // write response valid
	input  wire logic             s_axi_bready_i,  // write response ready
	input  wire logic [AW-1:0]    s_axi_araddr_i,  // read address
	input  wire logic             s_axi_arvalid_i, // read address valid
	output logic                  s_axi_arready_o, // read address ready
	output logic [DW-1:0]         s_axi_rdata_o,   // read data
	output logic [1:0]            s_axi_rresp_o,   // read response
	output logic                  s_axi_rvalid_o,  // read data valid
	input  wire logic             s_axi_rready_i,  // read data ready
	input  wire logic             sel_pin_i,       // external select pin
	input  wire ics_alarm_t       alarm_i,         // fault detector levels
	output logic                  locked_o,        // loop follows an input
	output logic                  active_input_o,  // 0 input zero, 1 input one
	output logic                  switchover_o,    // pulse on direct switch between the two inputs
	output logic [1:0]            rx_enable_o,     // receiver power enables
	output logic [1:0]            rx_pulsed_o      // pulsed receiver select
);

	function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] idx);
		return a[AW-1:2] == idx[AW-3:0];
	endfunction : hit

	function automatic ics_state_t pick(input logic [1:0] el, input logic [2:0] r0,
			input logic [2:0] r1);
		// lower nonzero rank wins; a tie goes to input zero
		if (el == 2'b11) begin
			return (r1 < r0) ? ST_IN1 : ST_IN0; // RQ9 RQ16
		end else if (el[0]) begin
			return ST_IN0;
		end else if (el[1]) begin
			return ST_IN1;
		end else begin
			return ST_HOLD; // RQ8
		end
	endfunction : pick

	// select pin synchroniser; s1 feeds only s2
	logic pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_s3_r <= 1'b0;
			pin_q_r  <= 1'b0;
		end else begin
			pin_s1_r <= sel_pin_i;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			if (pin_s2_r == pin_s3_r) begin
				pin_q_r <= pin_s3_r;
			end
		end
	end

	// bus slave
	ics_cfg_t          cfg_r, cfg_nxt;
	ics_state_t        state_r, state_nxt;
	logic              aw_held_r, w_held_r, bvalid_r, rvalid_r;
	logic [AW-1:0]     awaddr_r;
	logic [DW-1:0]     wdata_r, rdata_r;
	logic              wlane_r;
	logic [1:0]        bresp_r, rresp_r;
	logic              sw_r;
	logic [DW-1:0]     rd_word;
	logic              rd_ok;

	wire logic aw_take  = s_axi_awvalid_i && s_axi_awready_o;
	wire logic w_take   = s_axi_wvalid_i && s_axi_wready_o;
	wire logic ar_take  = s_axi_arvalid_i && s_axi_arready_o;
	wire logic do_write = aw_held_r && w_held_r && !bvalid_r;
	wire logic wr_map   = hit(awaddr_r, IDX_SEL_CTL) || hit(awaddr_r, IDX_SWITCH) ||
		hit(awaddr_r, IDX_MASK) || hit(awaddr_r, IDX_RANK) ||
		hit(awaddr_r, IDX_IN_CFG) || hit(awaddr_r, IDX_STATUS);
	// every field sits in byte lane 0
	wire logic wr_en    = do_write && wlane_r;

	assign s_axi_awready_o = !aw_held_r && !bvalid_r;
	assign s_axi_wready_o  = !w_held_r && !bvalid_r;
	assign s_axi_arready_o = !rvalid_r;
	assign s_axi_bvalid_o  = bvalid_r;
	assign s_axi_bresp_o   = bresp_r;
	assign s_axi_rvalid_o  = rvalid_r;
	assign s_axi_rdata_o   = rdata_r;
	assign s_axi_rresp_o   = rresp_r;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wlane_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr_i;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata_i;
				wlane_r  <= s_axi_wstrb_i[0];
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready_i) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// configuration writes
	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_en && hit(awaddr_r, IDX_SEL_CTL)) begin
			cfg_nxt.src_reg = wdata_r[SC_SRC]; // RQ2
			cfg_nxt.choice  = wdata_r[SC_CHOICE];
		end
		if (wr_en && hit(awaddr_r, IDX_SWITCH)) begin
			cfg_nxt.mode = ics_mode_t'(wdata_r[1:0]); // RQ1
		end
		if (wr_en && hit(awaddr_r, IDX_MASK)) begin
			cfg_nxt.los_msk = wdata_r[LOSM_LSB +: 4];
			cfg_nxt.oof_msk = wdata_r[OOFM_LSB +: 4];
		end
		if (wr_en && hit(awaddr_r, IDX_RANK)) begin
			cfg_nxt.rank0 = wdata_r[RANK0_LSB +: 3]; // RQ11
			cfg_nxt.rank1 = wdata_r[RANK1_LSB +: 3];
		end
		if (wr_en && hit(awaddr_r, IDX_IN_CFG)) begin
			cfg_nxt.rx_en     = wdata_r[EN_LSB +: 2]; // RQ14
			cfg_nxt.rx_pulsed = wdata_r[PUL_LSB +: 2]; // RQ15
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cfg_r <= '{src_reg: 1'b0, choice: 1'b0, mode: MODE_MANUAL, los_msk: 4'h0,
				oof_msk: 4'h0, rank0: RANK0_RST, rank1: RANK1_RST,
				rx_en: RX_EN_RST, rx_pulsed: 2'h0}; // RQ2 RQ15
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	assign rx_enable_o = cfg_r.rx_en; // RQ14
	assign rx_pulsed_o = cfg_r.rx_pulsed; // RQ15

	// input qualification; mask bits 3:2 are never looked at
	wire logic [1:0] loss_cnt  = alarm_i.signal_loss_alarm & ~cfg_r.los_msk[1:0]; // RQ12 RQ17
	wire logic [1:0] fault_cnt = alarm_i.frequency_fault_alarm & ~cfg_r.oof_msk[1:0]; // RQ13 RQ17
	wire logic [1:0] valid     = cfg_r.rx_en & ~loss_cnt & ~fault_cnt; // RQ7
	wire logic [1:0] elig      = valid & {|cfg_r.rank1, |cfg_r.rank0}; // RQ11
	// a clock is present when its receiver runs and shows no signal loss
	wire logic [1:0] present   = cfg_r.rx_en & ~alarm_i.signal_loss_alarm;
	wire logic       man_sel   = cfg_r.src_reg ? cfg_r.choice : pin_q_r; // RQ3
	wire ics_state_t best      = pick(elig, cfg_r.rank0, cfg_r.rank1);
	wire logic       cur_ok    = (state_r == ST_IN0 && elig[0]) ||
		(state_r == ST_IN1 && elig[1]);

	always_comb begin
		state_nxt = state_r;
		case (cfg_r.mode)
			MODE_MANUAL: begin
				if (!present[man_sel]) begin
					state_nxt = ST_HOLD; // RQ5
				end else begin
					state_nxt = man_sel ? ST_IN1 : ST_IN0; // RQ4
				end
			end
			MODE_NREV: begin
				// pin and choice bit play no part here
				state_nxt = cur_ok ? state_r : best; // RQ6 RQ10 RQ18
			end
			MODE_REV: begin
				state_nxt = best; // RQ6 RQ9 RQ18
			end
			default: begin
				// reserved code freezes the current choice
				state_nxt = state_r;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= ST_HOLD;
			sw_r    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sw_r    <= state_nxt[0] && state_r[0] && (state_nxt != state_r);
		end
	end

	assign locked_o       = state_r[0];
	assign active_input_o = state_r[1];
	assign switchover_o   = sw_r;

	// read decode
	always_comb begin
		rd_word = '0;
		rd_ok   = 1'b1;
		if (hit(s_axi_araddr_i, IDX_SEL_CTL)) begin
			rd_word[SC_SRC]    = cfg_r.src_reg;
			rd_word[SC_CHOICE] = cfg_r.choice;
		end else if (hit(s_axi_araddr_i, IDX_SWITCH)) begin
			rd_word[1:0] = cfg_r.mode;
		end else if (hit(s_axi_araddr_i, IDX_MASK)) begin
			rd_word[LOSM_LSB +: 4] = cfg_r.los_msk;
			rd_word[OOFM_LSB +: 4] = cfg_r.oof_msk;
		end else if (hit(s_axi_araddr_i, IDX_RANK)) begin
			rd_word[RANK0_LSB +: 3] = cfg_r.rank0;
			rd_word[RANK1_LSB +: 3] = cfg_r.rank1;
		end else if (hit(s_axi_araddr_i, IDX_IN_CFG)) begin
			rd_word[EN_LSB +: 2]  = cfg_r.rx_en;
			rd_word[PUL_LSB +: 2] = cfg_r.rx_pulsed;
		end else if (hit(s_axi_araddr_i, IDX_STATUS)) begin
			rd_word[1:0]         = state_r;
			rd_word[ST_VALID +: 2] = valid;
			rd_word[ST_ELIG +: 2]  = elig;
			rd_word[ST_PIN]      = pin_q_r;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready_i) begin
			rvalid_r <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	wire logic is_auto = cfg_r.mode == MODE_NREV || cfg_r.mode == MODE_REV;

	sequence s_in_hold;
		state_r == ST_HOLD;
	endsequence
	sequence s_input_back;
		is_auto && elig != 2'b00;
	endsequence

	chk_pin_control: assert property ( // RQ3
		cfg_r.mode == MODE_MANUAL && !cfg_r.src_reg && present[pin_q_r]
		|=> state_r == (($past(pin_q_r)) ? ST_IN1 : ST_IN0))
		else $error("manual pin choice not followed");
	chk_reg_choice: assert property ( // RQ4
		cfg_r.mode == MODE_MANUAL && cfg_r.src_reg && present[cfg_r.choice]
		|=> active_input_o == $past(cfg_r.choice) && locked_o)
		else $error("register choice not followed");
	chk_manual_noclock: assert property ( // RQ5
		cfg_r.mode == MODE_MANUAL && !present[man_sel] |=> !locked_o)
		else $error("manual input without clock kept");
	chk_auto_holdover: assert property ( // RQ8
		is_auto && elig == 2'b00 |=> state_r == ST_HOLD)
		else $error("no valid input but not in holdover");
	chk_revert_best: assert property ( // RQ9
		cfg_r.mode == MODE_REV && elig == 2'b11 && cfg_r.rank1 < cfg_r.rank0
		|=> state_r == ST_IN1)
		else $error("revertive mode missed better input");
	chk_nonrevert_keep: assert property ( // RQ10
		cfg_r.mode == MODE_NREV && state_r == ST_IN1 && elig[1]
		|=> state_r == ST_IN1 && !switchover_o)
		else $error("non-revertive mode left a valid input");
	chk_rank_zero: assert property ( // RQ11
		is_auto && cfg_r.rank0 == 3'h0 |=> state_r != ST_IN0)
		else $error("rank zero input selected");
	chk_tie_zero: assert property ( // RQ16
		cfg_r.mode == MODE_REV && elig == 2'b11 && cfg_r.rank0 == cfg_r.rank1
		|=> state_r == ST_IN0)
		else $error("tie not resolved to input zero");
	chk_loss_mask: assert property ( // RQ12
		alarm_i.signal_loss_alarm[0] && !cfg_r.los_msk[0] |-> !valid[0])
		else $error("unmasked signal loss ignored");
	chk_fault_mask: assert property ( // RQ13
		alarm_i.frequency_fault_alarm[1] && !cfg_r.oof_msk[1] |-> !valid[1])
		else $error("unmasked frequency fault ignored");
	chk_hold_exit: assert property ( // RQ18
		s_in_hold ##0 s_input_back |=> locked_o)
		else $error("holdover not left for valid input");
	chk_rx_write: assert property ( // RQ14
		wr_en && hit(awaddr_r, IDX_IN_CFG)
		|=> rx_enable_o == $past(wdata_r[EN_LSB +: 2]) && s_axi_bvalid_o)
		else $error("receiver enable write lost");
	chk_auto_no_pin: assert property ( // RQ6
		cfg_r.mode == MODE_REV && $stable(elig) && $stable(cfg_r) && state_r == best
		|=> $stable(state_r))
		else $error("automatic choice moved without cause");

endmodule : ics_input_clock_selector
`default_nettype wire

//--- core/ics_pkg.sv
// constants, types and register map of the input clock selector
// Operation
// RQ1 - mode field: 00 manual, 01 auto non-revertive, 02 auto revertive, 03 reserved
// RQ2 - manual mode: control bit picks pin or register select; pin after reset
// RQ3 - control bit low: register select bit ignored, pin chooses input
// RQ4 - select value 0 picks input zero, 1 picks input one
// RQ5 - manual choice without clock sends the loop to holdover by itself
// RQ6 - automatic modes ignore select pin and register select bit
// RQ7 - automatic selection uses only inputs with no unmasked alarm active
// RQ8 - automatic mode with no valid input enters holdover
// RQ9 - revertive: always highest-priority valid input, switch when better one valid
// RQ10 - non-revertive: keep active input while valid, else best valid input
// RQ11 - three-bit rank per input at 2:0 and 6:4; zero excludes
// RQ12 - signal-loss mask bit 0 counts loss, 1 ignores it
// RQ13 - frequency-fault mask bit 0 counts fault, 1 ignores it
// RQ14 - receiver enable bits: bit 1 input one, bit 0 input zero
// RQ15 - receiver type: 0 differential, 1 pulsed; both reset differential
// RQ16 - equal nonzero ranks with both valid choose input zero
// RQ17 - mask bit 0 for input zero, bit 1 input one, upper bits unused
// RQ18 - input valid again during holdover: leave holdover and lock to it
`default_nettype none
package ics_pkg;
	localparam int unsigned AW = 16;
	localparam int unsigned DW = 32;
	// register indices; byte address is four times the index
	localparam logic [AW-1:0] IDX_SEL_CTL  = 16'h052A;
	localparam logic [AW-1:0] IDX_SWITCH   = 16'h0536;
	localparam logic [AW-1:0] IDX_MASK     = 16'h0537;
	localparam logic [AW-1:0] IDX_RANK     = 16'h0538;
	localparam logic [AW-1:0] IDX_IN_CFG   = 16'h0949;
	localparam logic [AW-1:0] IDX_STATUS   = 16'h0540;
	// field positions
	localparam int unsigned SC_SRC    = 0;
	localparam int unsigned SC_CHOICE = 1;
	localparam int unsigned LOSM_LSB  = 0;
	localparam int unsigned OOFM_LSB  = 4;
	localparam int unsigned RANK0_LSB = 0;
	localparam int unsigned RANK1_LSB = 4;
	localparam int unsigned EN_LSB    = 0;
	localparam int unsigned PUL_LSB   = 4;
	localparam int unsigned ST_VALID  = 2;
	localparam int unsigned ST_ELIG   = 4;
	localparam int unsigned ST_PIN    = 6;
	typedef enum logic [1:0] {
		MODE_MANUAL = 2'h0,
		MODE_NREV   = 2'h1,
		MODE_REV    = 2'h2,
		MODE_RSVD   = 2'h3
	} ics_mode_t;
	// bit 0: locked to an input, bit 1: input one
	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_IN0  = 2'h1,
		ST_IN1  = 2'h3
	} ics_state_t;
	typedef struct packed {
		logic       src_reg;
		logic       choice;
		ics_mode_t  mode;
		logic [3:0] los_msk;
		logic [3:0] oof_msk;
		logic [2:0] rank0;
		logic [2:0] rank1;
		logic [1:0] rx_en;
		logic [1:0] rx_pulsed;
	} ics_cfg_t;
	typedef struct packed {
		logic [1:0] signal_loss_alarm;
		logic [1:0] frequency_fault_alarm;
	} ics_alarm_t;
	localparam logic [2:0] RANK0_RST = 3'h1;
	localparam logic [2:0] RANK1_RST = 3'h2;
	localparam logic [1:0] RX_EN_RST = 2'h3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ics_pkg
`default_nettype wire

//--- tb/ics_src_model.sv
// far side: two clock sources with fault levels and the select pin
`default_nettype none
module ics_src_model
	import ics_pkg::*;
(
	input  wire logic       ref_clk_i, // device clock
	input  wire logic       reset_i,   // async reset
	input  wire logic [1:0] lost_i,    // source stops
	input  wire logic [1:0] off_i,     // source drifts
	input  wire logic       pin_i,     // board select level
	output var ics_alarm_t  alarm_o,   // detector levels
	output logic            sel_pin_o  // select pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// detectors report one edge after the source misbehaves
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			alarm_o   <= '0;
			sel_pin_o <= 1'b0;
		end else begin
			alarm_o.signal_loss_alarm <= lost_i;
			alarm_o.frequency_fault_alarm <= off_i;
			sel_pin_o   <= pin_i;
		end
	end
endmodule : ics_src_model
`default_nettype wire

//--- tb/ics_input_clock_selector_tb_top.sv
// bench for the input clock selector
`default_nettype none
module ics_input_clock_selector_tb_top;
	import ics_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic             ref_clk = 1'b0;
	logic             rst = 1'b1;
	logic [AW-1:0]    awaddr = '0, araddr = '0;
	logic [DW-1:0]    wdata = '0, rdata;
	logic             awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic             awr, wr, bv, arr, rv, locked, act, swo, pin;
	logic [1:0]       bresp, rresp, rxen, rxpul, lost = '0, off = '0;
	logic             pin_req = 1'b0;
	ics_alarm_t       alarm;
	int               n_errors = 0, samples_checked = 0;
	always #5 ref_clk = ~ref_clk;
	ics_src_model src (.ref_clk_i(ref_clk), .reset_i(rst), .lost_i(lost), .off_i(off),
		.pin_i(pin_req), .alarm_o(alarm), .sel_pin_o(pin));
	ics_input_clock_selector uut (.ref_clk_i(ref_clk), .reset_i(rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .sel_pin_i(pin), .alarm_i(alarm),
		.locked_o(locked), .active_input_o(act), .switchover_o(swo),
		.rx_enable_o(rxen), .rx_pulsed_o(rxpul));
	task automatic test_done;
		$display("checked %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic hang;
		n_errors++;
		$display("Error at %0t: no bus answer", $time);
		test_done();
	endtask : hang
	// byte address is four times the register index
	task automatic wr_reg(input logic [AW-1:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic       a, w, b;
		logic [1:0] r;
		int         i;
		@(posedge ref_clk);
		awaddr <= AW'(idx << 2);
		wdata  <= 32'(d);
		awv    <= 1'b1;
		wv     <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge ref_clk);
			a = awr;
			w = wr;
			b = bv;
			r = bresp;
			@(posedge ref_clk);
			if (a) awv <= 1'b0;
			if (w) wv <= 1'b0;
			if (b) break;
		end
		bready <= 1'b0;
		if (i == 50) hang();
		cmp(32'(r), 32'(er));
	endtask : wr_reg
	task automatic rd_reg(input logic [AW-1:0] idx, input logic [7:0] ed, input logic [1:0] er);
		logic        a, v;
		logic [31:0] d;
		logic [1:0]  r;
		int          i;
		@(posedge ref_clk);
		araddr <= AW'(idx << 2);
		arv    <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge ref_clk);
			a = arr;
			v = rv;
			d = rdata;
			r = rresp;
			@(posedge ref_clk);
			if (a) arv <= 1'b0;
			if (v) break;
		end
		rready <= 1'b0;
		if (i == 50) hang();
		cmp(d, 32'(ed));
		cmp(32'(r), 32'(er));
	endtask : rd_reg
	// selection settles after a fixed number of edges
	task automatic chk_sel(input int n, input logic lk, input logic a);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
		cmp(32'({locked, lk ? act : 1'b0}), 32'({lk, a}));
	endtask : chk_sel
	task automatic set_flt(input logic [1:0] l, input logic [1:0] o);
		@(posedge ref_clk);
		lost <= l;
		off  <= o;
	endtask : set_flt
	task automatic t_reset;
		cmp(32'({rxen, rxpul}), 32'h0000_000C);
		rd_reg(IDX_RANK, 8'h21, RESP_OKAY);
		rd_reg(IDX_IN_CFG, 8'h03, RESP_OKAY);
		rd_reg(IDX_SEL_CTL, 8'h00, RESP_OKAY);
		rd_reg(16'h0100, 8'h00, RESP_SLVERR);
		wr_reg(16'h0100, 8'h00, RESP_SLVERR);
		chk_sel(0, 1'b1, 1'b0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_manual;
		wr_reg(IDX_SEL_CTL, 8'h02, RESP_OKAY);
		chk_sel(1, 1'b1, 1'b0);
		@(posedge ref_clk);
		pin_req <= 1'b1;
		chk_sel(6, 1'b1, 1'b1);
		wr_reg(IDX_SEL_CTL, 8'h01, RESP_OKAY);
		chk_sel(1, 1'b1, 1'b0);
		wr_reg(IDX_SEL_CTL, 8'h03, RESP_OKAY);
		chk_sel(1, 1'b1, 1'b1);
		set_flt(2'b10, 2'b00);
		chk_sel(2, 1'b0, 1'b0);
		set_flt(2'b00, 2'b00);
		chk_sel(2, 1'b1, 1'b1);
		wr_reg(IDX_IN_CFG, 8'h11, RESP_OKAY);
		cmp(32'({rxen, rxpul}), 32'h0000_0005);
		chk_sel(1, 1'b0, 1'b0);
		wr_reg(IDX_IN_CFG, 8'h03, RESP_OKAY);
		$display("manual test done");
	endtask : t_manual
	task automatic t_auto;
		int n;
		wr_reg(IDX_SWITCH, 8'h02, RESP_OKAY);
		chk_sel(1, 1'b1, 1'b0);
		set_flt(2'b01, 2'b00);
		chk_sel(2, 1'b1, 1'b1);
		set_flt(2'b00, 2'b00);
		n = 0;
		repeat (4) begin
			@(negedge ref_clk);
			n += int'(swo);
		end
		cmp(32'(n), 32'h0000_0001);
		chk_sel(0, 1'b1, 1'b0);
		wr_reg(IDX_SWITCH, 8'h01, RESP_OKAY);
		set_flt(2'b01, 2'b00);
		chk_sel(2, 1'b1, 1'b1);
		set_flt(2'b00, 2'b00);
		chk_sel(2, 1'b1, 1'b1);
		set_flt(2'b01, 2'b10);
		chk_sel(2, 1'b0, 1'b0);
		set_flt(2'b01, 2'b00);
		chk_sel(2, 1'b1, 1'b1);
		// reserved code must hold the current input even when it fails
		wr_reg(IDX_SWITCH, 8'h03, RESP_OKAY);
		set_flt(2'b10, 2'b00);
		chk_sel(2, 1'b1, 1'b1);
		$display("automatic test done");
	endtask : t_auto
	task automatic t_mask;
		set_flt(2'b00, 2'b00);
		wr_reg(IDX_SWITCH, 8'h02, RESP_OKAY);
		wr_reg(IDX_MASK, 8'h01, RESP_OKAY);
		set_flt(2'b01, 2'b00);
		chk_sel(2, 1'b1, 1'b0);
		wr_reg(IDX_MASK, 8'h10, RESP_OKAY);
		chk_sel(1, 1'b1, 1'b1);
		set_flt(2'b00, 2'b01);
		chk_sel(2, 1'b1, 1'b0);
		wr_reg(IDX_MASK, 8'hCC, RESP_OKAY);
		chk_sel(1, 1'b1, 1'b1);
		set_flt(2'b00, 2'b00);
		wr_reg(IDX_RANK, 8'h20, RESP_OKAY);
		chk_sel(1, 1'b1, 1'b1);
		wr_reg(IDX_RANK, 8'h22, RESP_OKAY);
		chk_sel(1, 1'b1, 1'b0);
		wr_reg(IDX_RANK, 8'h12, RESP_OKAY);
		chk_sel(1, 1'b1, 1'b1);
		// status: input one, both valid, both eligible, pin high
		rd_reg(IDX_STATUS, 8'h7F, RESP_OKAY);
		$display("mask and rank test done");
	endtask : t_mask
	initial begin
		repeat (6) @(posedge ref_clk);
		#2 rst = 1'b0;
		t_reset();
		t_manual();
		t_auto();
		t_mask();
		test_done();
	end
endmodule : ics_input_clock_selector_tb_top
`default_nettype wire
